// file: hw/fault_mgr_consts.vh
/*
 * Shared constants of the safe output fault manager: diagnostic class
 * codes, subcode values and vector widths.
 * Assumes it is included by bare name from the design files.
 */
`ifndef FAULT_MGR_CONSTS_VH
`define FAULT_MGR_CONSTS_VH

// Output count: main output plus three zones
`define NUM_OUTPUTS        4
`define SUBCODE_W          4
`define CLASS_W            12
`define CODE_W             16

// Error classes, upper twelve bits of a diagnostic code
`define CLS_READBACK_STUCK 12'h021
`define CLS_SHORT          12'h023
`define CLS_LIGHT_TEST     12'h025
`define CLS_DARK_TEST      12'h026
`define CLS_READBACK_DIFF  12'h028
`define CLS_NONE           12'h000

// Subcodes naming the affected output or switch
`define SUB_MAIN_HIGH      4'h0
`define SUB_ZONE_ONE       4'h1
`define SUB_MAIN_LOW       4'h8
`define SUB_ZONE_COMMON    4'h9

// Widths of the fault source groups
`define STUCK_W            3
`define SHORT_W            4
`define LIGHT_W            5
`define DARK_W             6
`define DIFF_W             3

// Index of the low side and common entries inside the test groups
`define LIGHT_LOW_IDX      4
`define DARK_LOW_IDX       4
`define DARK_COMMON_IDX    5

// Reset values
`define OUT_RESET          4'h0
`define CODE_RESET         16'h0000

`endif

// file: hw/pin_sync.v
/*
 * Two flip-flop synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is an independent level from a pin; no bus coherence.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!nrst) begin
            meta_r   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // pin_sync

// file: hw/fault_encoder.v
/*
 * Priority encoder turning latched fault vectors into one diagnostic code.
 * Assumes vectors are already latched; output is combinational.
 */
`timescale 1ns/1ps
`include "fault_mgr_consts.vh"

module fault_encoder (
    input  wire [`STUCK_W-1:0] stuck_lat,
    input  wire [`SHORT_W-1:0] short_lat,
    input  wire [`LIGHT_W-1:0] light_lat,
    input  wire [`DARK_W-1:0]  dark_lat,
    input  wire [`DIFF_W-1:0]  diff_lat,
    output reg  [`CODE_W-1:0]  code,
    output reg                 code_valid
);

    // Lowest set bit index, used for every group
    function [3:0] low_index;
        input [7:0] vec;
        integer     k;
        begin
            low_index = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (vec[k]) begin
                    low_index = k[3:0];
                end
            end
        end
    endfunction

    reg [3:0] idx;

    // Shutdown classes rank above the single-output short class
    always @* begin
        idx        = 4'h0;
        code       = `CODE_RESET;
        code_valid = 1'b0;
        if (|stuck_lat) begin
            idx        = low_index({5'h00, stuck_lat});
            code       = {`CLS_READBACK_STUCK, idx + `SUB_ZONE_ONE};   // see RQ1
            code_valid = 1'b1;
        end else if (|light_lat) begin
            idx        = low_index({3'h0, light_lat});
            code       = {`CLS_LIGHT_TEST,
                          (idx == `LIGHT_LOW_IDX) ? `SUB_MAIN_LOW : idx};  // see RQ6
            code_valid = 1'b1;
        end else if (|dark_lat) begin
            idx        = low_index({2'h0, dark_lat});
            code       = {`CLS_DARK_TEST,
                          (idx == `DARK_COMMON_IDX) ? `SUB_ZONE_COMMON :
                          (idx == `DARK_LOW_IDX)    ? `SUB_MAIN_LOW : idx};  // see RQ7
            code_valid = 1'b1;
        end else if (|diff_lat) begin
            idx        = low_index({5'h00, diff_lat});
            code       = {`CLS_READBACK_DIFF,
                          (idx == 4'h0) ? `SUB_MAIN_HIGH :
                          (idx == 4'h1) ? `SUB_MAIN_LOW : `SUB_ZONE_COMMON};  // see RQ8
            code_valid = 1'b1;
        end else if (|short_lat) begin
            idx        = low_index({4'h0, short_lat});
            code       = {`CLS_SHORT, idx};                             // see RQ4
            code_valid = 1'b1;
        end
    end

endmodule // fault_encoder

// file: hw/safe_output_fault_manager.v
/*
 * Fault supervision for a safety digital output module: latches detected
 * output faults, forces outputs to the safe state, drives red indicators,
 * reports a diagnostic code and gates start-up.
 * Assumes detector flags arrive asynchronously from pins; demands, the
 * acknowledge and start-up status come from logic on clk.
 */
`timescale 1ns/1ps
`include "fault_mgr_consts.vh"

// Functional notes
// RQ1: Code holds class high, output id low nibble
// RQ2: Zone readback stuck forces all outputs safe
// RQ3: Global ack restarts only if nothing pending
// RQ4: Short reports class 023, lights own indicator
// RQ5: Short ack restarts affected output only
// RQ6: Light test failure forces all outputs safe
// RQ7: Dark test failure forces all outputs safe
// RQ8: Readback mismatch holds all outputs safe
// RQ9: No operation before parameters and self-test
// RQ10: Safety input returns to one automatically
// RQ11: Ack returns safe input immediately to operation
// RQ12: Shorted output indicator stays steadily red
// RQ13: Faults latch; ack ignored while cause active
module safe_output_fault_manager (
    input  wire                    clk,
    input  wire                    nrst,
    input  wire [`NUM_OUTPUTS-1:0] out_demand,
    input  wire                    fault_ack,
    input  wire                    param_loaded,
    input  wire                    selftest_done,
    input  wire                    selftest_error,
    input  wire                    safety_trigger,
    input  wire [`STUCK_W-1:0]     readback_stuck,
    input  wire [`SHORT_W-1:0]     short_detect,
    input  wire [`LIGHT_W-1:0]     light_test_fail,
    input  wire [`DARK_W-1:0]      dark_test_fail,
    input  wire [`DIFF_W-1:0]      readback_diff,
    output reg  [`NUM_OUTPUTS-1:0] out_enable_r,
    output reg  [`NUM_OUTPUTS-1:0] led_red_r,
    output reg  [`CODE_W-1:0]      diag_code_r,
    output reg                     diag_valid_r,
    output reg                     all_safe_r,
    output reg                     running_r,
    output reg                     safe_input_r
);

    localparam DET_W = `STUCK_W + `SHORT_W + `LIGHT_W + `DARK_W + `DIFF_W + 1;

    // Start-up states, one-hot
    localparam [2:0] ST_WAIT  = 3'b001;
    localparam [2:0] ST_RUN   = 3'b010;
    localparam [2:0] ST_ERROR = 3'b100;

    wire [DET_W-1:0]        det_raw;
    wire [DET_W-1:0]        det_sync;
    wire [`STUCK_W-1:0]     stuck_now;
    wire [`SHORT_W-1:0]     short_now;
    wire [`LIGHT_W-1:0]     light_now;
    wire [`DARK_W-1:0]      dark_now;
    wire [`DIFF_W-1:0]      diff_now;
    wire                    trigger_now;

    reg  [`STUCK_W-1:0]     stuck_r;
    reg  [`SHORT_W-1:0]     short_r;
    reg  [`LIGHT_W-1:0]     light_r;
    reg  [`DARK_W-1:0]      dark_r;
    reg  [`DIFF_W-1:0]      diff_r;
    reg  [`STUCK_W-1:0]     stuck_nxt;
    reg  [`SHORT_W-1:0]     short_nxt;
    reg  [`LIGHT_W-1:0]     light_nxt;
    reg  [`DARK_W-1:0]      dark_nxt;
    reg  [`DIFF_W-1:0]      diff_nxt;
    reg  [2:0]              state_r;
    reg  [2:0]              state_nxt;
    reg                     ack_d_r;
    reg  [`NUM_OUTPUTS-1:0] out_enable_nxt;
    reg  [`NUM_OUTPUTS-1:0] led_red_nxt;

    wire                    ack_pulse;
    wire                    global_now;
    wire                    global_lat_nxt;
    wire                    global_ack_ok;
    wire [`CODE_W-1:0]      enc_code;
    wire                    enc_valid;

    // All detector pins cross into clk through one synchroniser bank
    assign det_raw = {safety_trigger, readback_diff, dark_test_fail,
                      light_test_fail, short_detect, readback_stuck};

    pin_sync #(
        .WIDTH    (DET_W)
    ) u_det_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (det_raw),
        .sync_out (det_sync)
    );

    // Split the synchronised bank back into its groups
    assign stuck_now   = det_sync[`STUCK_W-1:0];
    assign short_now   = det_sync[`STUCK_W+`SHORT_W-1:`STUCK_W];
    assign light_now   = det_sync[`STUCK_W+`SHORT_W+`LIGHT_W-1:`STUCK_W+`SHORT_W];
    assign dark_now    = det_sync[DET_W-`DIFF_W-2:DET_W-`DIFF_W-`DARK_W-1];
    assign diff_now    = det_sync[DET_W-2:DET_W-`DIFF_W-1];
    assign trigger_now = det_sync[DET_W-1];

    // Acknowledge acts on its rising edge so a held level clears once
    assign ack_pulse = fault_ack & ~ack_d_r;

    always @(posedge clk) begin
        if (!nrst) begin
            ack_d_r <= 1'b0;
        end else begin
            ack_d_r <= fault_ack;
        end
    end

    // Any detector of a shutting-down class still asserted
    assign global_now = (|stuck_now) | (|light_now) | (|dark_now) | (|diff_now);

    // Global faults clear together, and only with every cause gone
    assign global_ack_ok = ack_pulse & ~global_now;        // see RQ3, RQ13

    // Latch update; a new detection always wins over a clear
    always @* begin
        stuck_nxt = stuck_r;
        light_nxt = light_r;
        dark_nxt  = dark_r;
        diff_nxt  = diff_r;
        short_nxt = short_r;
        if (global_ack_ok) begin
            stuck_nxt = {`STUCK_W{1'b0}};                   // see RQ3
            light_nxt = {`LIGHT_W{1'b0}};
            dark_nxt  = {`DARK_W{1'b0}};
            diff_nxt  = {`DIFF_W{1'b0}};
        end
        if (ack_pulse) begin
            short_nxt = short_r & short_now;                // see RQ5, RQ13
        end
        stuck_nxt = stuck_nxt | stuck_now;                  // see RQ2, RQ13
        light_nxt = light_nxt | light_now;                  // see RQ6
        dark_nxt  = dark_nxt | dark_now;                    // see RQ7
        diff_nxt  = diff_nxt | diff_now;                    // see RQ8
        short_nxt = short_nxt | short_now;                  // see RQ4
    end

    always @(posedge clk) begin
        if (!nrst) begin
            stuck_r <= {`STUCK_W{1'b0}};
            short_r <= {`SHORT_W{1'b0}};
            light_r <= {`LIGHT_W{1'b0}};
            dark_r  <= {`DARK_W{1'b0}};
            diff_r  <= {`DIFF_W{1'b0}};
        end else begin
            stuck_r <= stuck_nxt;
            short_r <= short_nxt;
            light_r <= light_nxt;
            dark_r  <= dark_nxt;
            diff_r  <= diff_nxt;
        end
    end

    assign global_lat_nxt = (|stuck_nxt) | (|light_nxt) | (|dark_nxt) | (|diff_nxt);

    // Start-up gate: a failed self-test keeps the outputs dead for good
    always @* begin
        case (state_r)
            ST_WAIT: begin
                if (selftest_done && selftest_error) begin
                    state_nxt = ST_ERROR;
                end else if (param_loaded && selftest_done) begin
                    state_nxt = ST_RUN;                     // see RQ9
                end else begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            ST_ERROR: begin
                state_nxt = ST_ERROR;
            end
            default: begin
                state_nxt = ST_WAIT;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_WAIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Per-output enable and indicator, one generate slice per output
    genvar g;
    generate
        for (g = 0; g < `NUM_OUTPUTS; g = g + 1) begin : g_out
            always @* begin
                out_enable_nxt[g] = (state_nxt == ST_RUN) & out_demand[g]
                                    & ~global_lat_nxt        // see RQ2, RQ6, RQ7, RQ8
                                    & ~short_nxt[g];         // see RQ5
                led_red_nxt[g]    = global_lat_nxt | short_nxt[g];  // see RQ4, RQ12
            end
        end
    endgenerate

    // Diagnostic code of the highest ranking latched fault
    fault_encoder u_enc (
        .stuck_lat  (stuck_nxt),
        .short_lat  (short_nxt),
        .light_lat  (light_nxt),
        .dark_lat   (dark_nxt),
        .diff_lat   (diff_nxt),
        .code       (enc_code),
        .code_valid (enc_valid)
    );

    // Registered outputs; outputs are off from reset onward
    always @(posedge clk) begin
        if (!nrst) begin
            out_enable_r <= `OUT_RESET;
            led_red_r    <= `OUT_RESET;
            diag_code_r  <= `CODE_RESET;
            diag_valid_r <= 1'b0;
            all_safe_r   <= 1'b1;
            running_r    <= 1'b0;
            safe_input_r <= 1'b0;
        end else begin
            out_enable_r <= out_enable_nxt;
            led_red_r    <= led_red_nxt;
            diag_code_r  <= enc_code;                       // see RQ1
            diag_valid_r <= enc_valid;
            all_safe_r   <= global_lat_nxt | (state_nxt != ST_RUN);
            running_r    <= (state_nxt == ST_RUN);
            // Back to one when trigger drops and no shutdown is latched
            safe_input_r <= (state_nxt == ST_RUN) & ~trigger_now
                            & ~global_lat_nxt;               // see RQ10, RQ11
        end
    end

endmodule // safe_output_fault_manager

// file: dv/fault_mgr_props.sv
/* Port checker for the safe output fault manager.
   Assumes one clock domain and the top module's port widths. */
`timescale 1ns/1ps
module fault_mgr_props (
    input wire       clk,
    input wire       nrst,
    input wire [3:0] out_demand,
    input wire       param_loaded,
    input wire       selftest_done,
    input wire       selftest_error,
    input wire       safety_trigger,
    input wire [3:0] short_detect,
    input wire [2:0] readback_stuck,
    input wire [4:0] light_test_fail,
    input wire [5:0] dark_test_fail,
    input wire [2:0] readback_diff,
    input wire [3:0] out_enable_r,
    input wire [3:0] led_red_r,
    input wire [15:0] diag_code_r,
    input wire       diag_valid_r,
    input wire       all_safe_r,
    input wire       running_r,
    input wire       safe_input_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Class and subcode views of the code
    wire [11:0] cls = diag_code_r[15:4];
    wire [3:0]  sub = diag_code_r[3:0];
    wire        glob = |{readback_stuck, light_test_fail, dark_test_fail, readback_diff};
    a_idle_before_run: assert property (!running_r |-> out_enable_r == 4'h0 && all_safe_r)
        else $error("outputs live before start");
    a_start_gate: assert property ($rose(running_r) |->
        $past(param_loaded && selftest_done && !selftest_error)) else $error("start ungated");
    a_demand_only: assert property ((out_enable_r & ~$past(out_demand)) == 4'h0)
        else $error("enable without demand");
    a_red_is_off: assert property ((out_enable_r & led_red_r) == 4'h0)
        else $error("red output still on");
    a_code_valid: assert property (diag_valid_r == (diag_code_r != 16'h0000))
        else $error("code and valid disagree");
    a_subcode_legal: assert property (diag_valid_r |->
        (cls == 12'h021 && sub >= 4'h1 && sub <= 4'h3) || (cls == 12'h023 && sub <= 4'h3) ||
        (cls == 12'h025 && (sub <= 4'h3 || sub == 4'h8)) ||
        (cls == 12'h026 && (sub <= 4'h3 || sub == 4'h8 || sub == 4'h9)) ||
        (cls == 12'h028 && (sub == 4'h0 || sub == 4'h8 || sub == 4'h9)))
        else $error("illegal code");
    a_global_all_safe: assert property (diag_valid_r && cls != 12'h023 |->
        all_safe_r && led_red_r == 4'hf) else $error("global fault not safe");
    a_global_held: assert property (glob [*5] |-> all_safe_r)
        else $error("global fault released");
    a_short_red: assert property ((running_r && short_detect[0]) [*5] |-> led_red_r[0])
        else $error("short not red");
    a_trigger_safe: assert property (safety_trigger [*5] |-> !safe_input_r)
        else $error("safe input on under trigger");
    c_start: cover property ($rose(running_r));
    c_short: cover property (diag_valid_r && cls == 12'h023);
    c_global: cover property (diag_valid_r && cls == 12'h026);
    c_clear: cover property ($fell(diag_valid_r));
endmodule // fault_mgr_props
bind safe_output_fault_manager fault_mgr_props i_fault_mgr_props (.clk(clk), .nrst(nrst),
    .out_demand(out_demand), .param_loaded(param_loaded), .selftest_done(selftest_done),
    .selftest_error(selftest_error), .safety_trigger(safety_trigger),
    .short_detect(short_detect), .readback_stuck(readback_stuck),
    .light_test_fail(light_test_fail), .dark_test_fail(dark_test_fail),
    .readback_diff(readback_diff), .out_enable_r(out_enable_r), .led_red_r(led_red_r),
    .diag_code_r(diag_code_r), .diag_valid_r(diag_valid_r), .all_safe_r(all_safe_r),
    .running_r(running_r), .safe_input_r(safe_input_r));

// file: dv/safety_ctrl_model.sv
/* Safety controller model: output demands and acknowledgements.
   Assumes the bench may also ask for an ack while the fault cause is still active. */
`timescale 1ns/1ps
module safety_ctrl_model (
    input  wire       clk,
    input  wire [3:0] demand_req,
    input  wire       ack_req,
    output reg  [3:0] out_demand,
    output reg        fault_ack
);
    initial begin
        out_demand = 4'h0;
        fault_ack  = 1'b0;
    end
    // Launch on the falling edge, clear of the sampling edge
    always @(negedge clk) begin
        out_demand <= demand_req;
        fault_ack  <= ack_req;
    end
endmodule // safety_ctrl_model

// file: dv/test_safe_output_fault_manager.sv
/* Self-checking bench for the safe output fault manager.
   Assumes the controller model and the bound port checker. */
`timescale 1ns/1ps
module test_safe_output_fault_manager;
    reg         clk, nrst, ack_req, param_loaded, selftest_done, selftest_error, safety_trigger;
    reg  [3:0]  demand_req;
    reg  [20:0] flt;
    wire [3:0]  out_demand, out_enable_r, led_red_r;
    wire        fault_ack, diag_valid_r, all_safe_r, running_r, safe_input_r;
    wire [15:0] diag_code_r;
    integer     n_fail = 0, comparisons = 0, k;
    // Snapshot for the settle loop
    wire [25:0] snap = {out_enable_r, led_red_r, diag_code_r, all_safe_r, safe_input_r};
    safety_ctrl_model i_safety_ctrl_model (.clk(clk), .demand_req(demand_req),
        .ack_req(ack_req), .out_demand(out_demand), .fault_ack(fault_ack));
    safe_output_fault_manager i_safe_output_fault_manager (.clk(clk), .nrst(nrst),
        .out_demand(out_demand), .fault_ack(fault_ack), .param_loaded(param_loaded),
        .selftest_done(selftest_done), .selftest_error(selftest_error),
        .safety_trigger(safety_trigger), .readback_stuck(flt[2:0]), .short_detect(flt[6:3]),
        .light_test_fail(flt[11:7]), .dark_test_fail(flt[17:12]), .readback_diff(flt[20:18]),
        .out_enable_r(out_enable_r), .led_red_r(led_red_r), .diag_code_r(diag_code_r),
        .diag_valid_r(diag_valid_r), .all_safe_r(all_safe_r), .running_r(running_r),
        .safe_input_r(safe_input_r));
    always #50 clk = ~clk;
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task finish_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Wide enough for the longest packed comparison used below
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait until the outputs stop moving
    task settle;
        integer i;
        logic [25:0] prev;
        prev = 'x;
        for (i = 0; i < 20 && prev !== snap; i++) begin
            prev = snap;
            cyc(4);
        end
        if (prev !== snap) begin
            n_fail = n_fail + 1;
            finish_test;
        end
    endtask
    task do_reset;
        nrst = 1'b0;
        cyc(12);
        nrst = 1'b1;
        settle;
    endtask
    // Let a dropped detector clear the synchroniser before the ack edge
    task ack;
        cyc(3);
        ack_req = 1'b1;
        cyc(2);
        ack_req = 1'b0;
        settle;
    endtask
    // Expected code of global fault k: stuck, light, dark, then readback
    function [15:0] gcode(input integer k);
        if (k < 3) gcode = {12'h021, 4'(k + 1)};
        else if (k < 8) gcode = {12'h025, (k == 7) ? 4'h8 : 4'(k - 3)};
        else if (k < 14) gcode = {12'h026, (k > 11) ? 4'(k - 4) : 4'(k - 8)};
        else gcode = {12'h028, (k == 14) ? 4'h0 : 4'(k - 7)};
    endfunction
    task t_selftest_fail;
        check(running_r, 1'b0);
        check(out_enable_r, 4'h0);
        $display("selftest fail done");
    endtask
    task t_startup;
        check(out_enable_r, 4'h0);
        param_loaded = 1'b1;
        settle;
        check(running_r, 1'b0);
        selftest_done = 1'b1;
        settle;
        check({running_r, safe_input_r, out_enable_r}, 6'h3f);
        demand_req = 4'h5;
        settle;
        check(out_enable_r, 4'h5);
        demand_req = 4'hf;
        settle;
        $display("startup done");
    endtask
    task t_short;
        for (k = 0; k < 4; k++) begin
            flt[k + 3] = 1'b1;
            settle;
            check(diag_code_r, {12'h023, 4'(k)});
            check({led_red_r, out_enable_r}, {4'h1 << k, ~(4'h1 << k)});
            ack;
            check(led_red_r, 4'h1 << k);
            flt = '0;
            ack;
            check({diag_code_r, out_enable_r, led_red_r}, 24'h000f0);
        end
        $display("short done");
    endtask
    task t_global;
        for (k = 0; k < 17; k++) begin
            flt[(k < 3) ? k : k + 4] = 1'b1;
            settle;
            check(diag_code_r, gcode(k));
            check(diag_valid_r, 1'b1);
            check({all_safe_r, safe_input_r, out_enable_r, led_red_r}, 10'h20f);
            flt = '0;
            ack;
            check({diag_code_r, all_safe_r, safe_input_r, out_enable_r}, 22'h1f);
        end
        $display("global done");
    endtask
    task t_pending;
        flt[0] = 1'b1;
        flt[20] = 1'b1;
        settle;
        flt[0] = 1'b0;
        ack;
        check(all_safe_r, 1'b1);
        flt[20] = 1'b0;
        ack;
        check({all_safe_r, out_enable_r}, 5'h0f);
        $display("pending done");
    endtask
    task t_trigger;
        safety_trigger = 1'b1;
        settle;
        check(safe_input_r, 1'b0);
        safety_trigger = 1'b0;
        settle;
        check(safe_input_r, 1'b1);
        $display("trigger done");
    endtask
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        ack_req = 1'b0;
        demand_req = 4'hf;
        param_loaded = 1'b1;
        selftest_done = 1'b1;
        selftest_error = 1'b1;
        safety_trigger = 1'b0;
        flt = '0;
        do_reset;
        t_selftest_fail;
        {param_loaded, selftest_done, selftest_error} = 3'h0;
        do_reset;
        t_startup;
        t_short;
        t_global;
        t_pending;
        t_trigger;
        finish_test;
    end
endmodule // test_safe_output_fault_manager
